// ===== rtl/pip_pixel_input_port.sv
`timescale 1ns/1ps
// How it works
// [R1] straps 1010 pick the 18-bit 8080-II parallel bus; latched after reset.
// [R2] select line low carries a command; after the memory write command each high transfer is one pixel.
// [R3] mcu 16 bpp: red d15..11, green d10..5, blue d4..0, d17/d16 ignored.
// [R4] mcu 18 bpp: red d17..12, green d11..6, blue d5..0, one transfer.
// [R5] six-bit select high uses rgb data on d5..0.
// [R6] de timing mode: only transfers with data enable high go to memory.
// [R7] sync mode: pixels taken inside the porch-placed window.
// [R8] six-bit mode: phase counter builds one pixel from three clock transfers.
// [R9] falling vsync forces the phase counter back to the first transfer.
// [R10] a miscounted frame is realigned at the next frame start.
// [R11] controller sends three-clock multiples per frame in six-bit mode.
// [R12] the controller grounds unused data pins in six-bit mode.
// [R13] rgb format 101 uses 16-bit rgb data on d15..0.
// [R14] the controller grounds d16 and d17 in 16-bit rgb mode.
// [R15] rgb format 110 uses 18-bit rgb data on d17..0.
// [R16] with rgb video on, config comes over the serial port only.
// [R17] de mode drops transfers with data enable low, no advance.
module pip_pixel_input_port
    import pip_pkg::*;
#(
    parameter int         H_ACTIVE      = DEF_H_ACTIVE,
    parameter int         V_ACTIVE      = DEF_V_ACTIVE,
    parameter int         FIFO_DEPTH    = DEF_FIFO_DEPTH,
    parameter logic [7:0] MEM_WRITE_CMD = DEF_MEM_WRITE_CMD
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // straps and parallel mcu bus pins
    input  wire logic [3:0]  interface_mode_straps,
    input  wire logic        chip_select_n,
    input  wire logic        write_strobe_n,
    input  wire logic        data_command_select,
    input  wire logic [17:0] data_pins,
    // rgb video pins
    input  wire logic        pixel_clock,
    input  wire logic        vsync_n,
    input  wire logic        hsync_n,
    input  wire logic        data_enable,
    // rgb controls from the serial-port registers
    input  wire logic        rgb_interface_enable,
    input  wire logic        rgb_six_bit_select,
    input  wire logic [1:0]  rgb_timing_mode,
    input  wire logic [7:0]  vertical_porch_settings,
    input  wire logic [7:0]  horizontal_porch_settings,
    // serial-port register write, same clock
    input  wire logic        spi_cfg_write,
    input  wire logic [7:0]  spi_cfg_addr,
    input  wire logic [7:0]  spi_cfg_data,
    // status and command report
    output logic      [7:0]  pixel_format_config,
    output logic             mcu_mode_active,
    output logic             command_strobe,
    output logic      [7:0]  command_code,
    output logic      [1:0]  transfer_phase,
    output logic             transfer_mismatch,
    output logic             accept_ready,
    // pixel stream toward frame memory
    output logic             pix_valid,
    input  wire logic        pix_ready,
    output logic      [17:0] pix_data,
    output logic             pix_frame_start
);

    pip_pins_t       pins_raw;
    pip_pins_t       sync_meta;
    pip_pins_t       sync_pins;
    pip_pins_t       pins_last;

    logic [1:0]      strap_taken;
    logic [3:0]      straps_latched;
    pip_mcu_state_t  mcu_state;
    logic            frame_pending;
    logic [11:0]     h_count;
    logic [9:0]      v_count;
    logic [5:0]      red_part;
    logic [5:0]      green_part;

    logic [1:0]      next_strap_taken;
    logic [3:0]      next_straps_latched;
    pip_mcu_state_t  next_mcu_state;
    logic [7:0]      next_pixel_format_config;
    logic            next_command_strobe;
    logic [7:0]      next_command_code;
    logic            next_frame_pending;
    logic [11:0]     next_h_count;
    logic [9:0]      next_v_count;
    logic [1:0]      next_transfer_phase;
    logic            next_transfer_mismatch;
    logic [5:0]      next_red_part;
    logic [5:0]      next_green_part;

    logic            wr_rise;
    logic            pclk_rise;
    logic            vs_fall;
    logic            hs_fall;
    logic [7:0]      bus_byte;
    logic [2:0]      mcu_fmt;
    logic [2:0]      rgb_fmt;
    logic [11:0]     h_lo;
    logic [11:0]     h_hi;
    logic [9:0]      v_lo;
    logic [9:0]      v_hi;
    logic            in_window;
    logic            rgb_take;
    logic            push_valid;
    logic [17:0]     push_pixel;
    logic            push_start;

    pip_stream_if #(.W(ENTRY_W)) fill_if ();
    pip_stream_if #(.W(ENTRY_W)) drain_if ();

    assign pins_raw = {interface_mode_straps, chip_select_n, write_strobe_n, data_command_select,
                       data_pins, pixel_clock, vsync_n, hsync_n, data_enable};

    // two sync flops per pin; a third copy finds edges
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync_meta <= PINS_IDLE;
            sync_pins <= PINS_IDLE;
            pins_last <= PINS_IDLE;
        end else begin
            sync_meta <= pins_raw;
            sync_pins <= sync_meta;
            pins_last <= sync_pins;
        end
    end

    assign mcu_mode_active = (strap_taken == 2'h3) && (straps_latched == IM_PAR18_II) && !rgb_interface_enable; // [R1]
    assign wr_rise   = mcu_mode_active && !sync_pins.cs_n && sync_pins.wr_n && !pins_last.wr_n;
    assign pclk_rise = sync_pins.pclk && !pins_last.pclk;
    assign vs_fall   = !sync_pins.vs_n && pins_last.vs_n;
    assign hs_fall   = !sync_pins.hs_n && pins_last.hs_n;
    assign bus_byte  = sync_pins.data[CMD_LSB +: 8];
    assign mcu_fmt   = pixel_format_config[MCU_FMT_LSB +: 3];
    assign rgb_fmt   = pixel_format_config[RGB_FMT_LSB +: 3];

    // active window in pixel-clock units; six-bit mode needs three clocks per pixel
    assign h_lo      = {4'h0, horizontal_porch_settings};
    assign h_hi      = h_lo + (rgb_six_bit_select ? 12'(XFERS_6BIT * H_ACTIVE) : 12'(H_ACTIVE));
    assign v_lo      = {2'h0, vertical_porch_settings};
    assign v_hi      = v_lo + 10'(V_ACTIVE);
    assign in_window = (h_count >= h_lo) && (h_count < h_hi) && (v_count >= v_lo) && (v_count < v_hi); // [R7]

    always_comb begin
        rgb_take = 1'b0;
        if (rgb_interface_enable && pclk_rise && !vs_fall) begin
            case (rgb_timing_mode)
                RGB_TIMING_DE:   rgb_take = sync_pins.de;                   // [R6] [R17]
                RGB_TIMING_SYNC: rgb_take = in_window;                      // [R7]
                default:         rgb_take = 1'b0;
            endcase
        end
    end

    always_comb begin
        next_strap_taken         = strap_taken;
        next_straps_latched      = straps_latched;
        next_mcu_state           = mcu_state;
        next_pixel_format_config = pixel_format_config;
        next_command_strobe      = 1'b0;
        next_command_code        = command_code;
        next_frame_pending       = frame_pending;
        next_h_count             = h_count;
        next_v_count             = v_count;
        next_transfer_phase      = transfer_phase;
        next_transfer_mismatch   = 1'b0;
        next_red_part            = red_part;
        next_green_part          = green_part;
        push_valid               = 1'b0;
        push_pixel               = '0;

        // wait out the sync flops' reset values
        if (strap_taken != 2'h3) begin
            next_strap_taken = strap_taken + 2'h1;
        end
        if (strap_taken == 2'h2) begin
            next_straps_latched = sync_pins.straps;                         // [R1]
        end

        if (wr_rise) begin
            if (!sync_pins.dc) begin
                next_command_strobe = 1'b1;                                 // [R2]
                next_command_code   = bus_byte;
                if (bus_byte == REG_PIXEL_FORMAT_CONFIG) begin
                    next_mcu_state = MCU_PARAM;
                end else if (bus_byte == MEM_WRITE_CMD) begin
                    next_mcu_state     = MCU_PIXELS;
                    next_frame_pending = 1'b1;
                end else begin
                    next_mcu_state = MCU_IDLE;
                end
            end else begin
                case (mcu_state)
                    MCU_PARAM: begin
                        next_pixel_format_config = bus_byte;
                        next_mcu_state           = MCU_IDLE;
                    end
                    MCU_PIXELS: begin
                        // unknown formats are dropped rather than guessed
                        push_valid = pip_fmt_ok(mcu_fmt);                   // [R2]
                        push_pixel = pip_unpack(mcu_fmt, sync_pins.data);   // [R3] [R4]
                    end
                    default: ;
                endcase
            end
        end

        // serial port is the only config path once rgb video is on
        if (spi_cfg_write && spi_cfg_addr == REG_PIXEL_FORMAT_CONFIG) begin
            next_pixel_format_config = spi_cfg_data;                        // [R16]
        end

        if (rgb_interface_enable) begin
            if (vs_fall) begin
                next_transfer_mismatch = rgb_six_bit_select && (transfer_phase != PHASE_FIRST); // [R10]
                next_transfer_phase    = PHASE_FIRST;                       // [R9] [R10]
                next_h_count           = '0;
                next_v_count           = '0;
                next_frame_pending     = 1'b1;
            end else if (hs_fall) begin
                next_h_count = '0;
                next_v_count = (v_count == '1) ? v_count : v_count + 1'b1;
            end else if (pclk_rise) begin
                next_h_count = (h_count == '1) ? h_count : h_count + 1'b1;
            end

            if (rgb_take) begin
                if (rgb_six_bit_select) begin
                    case (transfer_phase)                                   // [R5] [R8]
                        PHASE_FIRST: begin
                            next_red_part       = sync_pins.data[5:0];
                            next_transfer_phase = PHASE_SECOND;
                        end
                        PHASE_SECOND: begin
                            next_green_part     = sync_pins.data[5:0];
                            next_transfer_phase = PHASE_THIRD;
                        end
                        PHASE_THIRD: begin
                            push_valid          = 1'b1;
                            push_pixel          = {red_part, green_part, sync_pins.data[5:0]};
                            next_transfer_phase = PHASE_FIRST;
                        end
                        default: next_transfer_phase = PHASE_FIRST;
                    endcase
                end else begin
                    push_valid = pip_fmt_ok(rgb_fmt);                       // [R13] [R15]
                    push_pixel = pip_unpack(rgb_fmt, sync_pins.data);
                end
            end
        end

        push_start = frame_pending;
        if (push_valid && !(rgb_interface_enable && vs_fall)) begin
            next_frame_pending = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            strap_taken         <= 2'h0;
            straps_latched      <= 4'h0;
            mcu_state           <= MCU_IDLE;
            pixel_format_config <= PIXEL_FORMAT_CONFIG_RESET;
            command_strobe      <= 1'b0;
            command_code        <= 8'h00;
            frame_pending       <= 1'b0;
            h_count             <= 12'h000;
            v_count             <= 10'h000;
            transfer_phase      <= PHASE_FIRST;
            transfer_mismatch   <= 1'b0;
            red_part            <= 6'h00;
            green_part          <= 6'h00;
        end else begin
            strap_taken         <= next_strap_taken;
            straps_latched      <= next_straps_latched;
            mcu_state           <= next_mcu_state;
            pixel_format_config <= next_pixel_format_config;
            command_strobe      <= next_command_strobe;
            command_code        <= next_command_code;
            frame_pending       <= next_frame_pending;
            h_count             <= next_h_count;
            v_count             <= next_v_count;
            transfer_phase      <= next_transfer_phase;
            transfer_mismatch   <= next_transfer_mismatch;
            red_part            <= next_red_part;
            green_part          <= next_green_part;
        end
    end

    // pins carry no handshake, so accept_ready tells the host to pace itself;
    // a pixel offered while it is low is lost
    assign fill_if.valid   = push_valid;
    assign fill_if.data    = {push_start, push_pixel};
    assign accept_ready    = fill_if.ready;

    pip_fifo #(
        .WIDTH (ENTRY_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock (clock),
        .rst_n (rst_n),
        .wr    (fill_if.snk),
        .rd    (drain_if.src)
    );

    assign drain_if.ready  = pix_ready;
    assign pix_valid       = drain_if.valid;
    assign pix_data        = drain_if.data[PIXEL_W-1:0];
    assign pix_frame_start = drain_if.data[PIXEL_W];

endmodule // pip_pixel_input_port

// ===== inc/pip_pkg.sv
package pip_pkg;

    // interface-mode strap pattern for the 18-bit 8080-II parallel bus
    localparam logic [3:0] IM_PAR18_II                = 4'ha;

    // register map, reached by command code on the parallel bus or the serial port
    localparam logic [7:0] REG_PIXEL_FORMAT_CONFIG    = 8'h3a;
    localparam logic [7:0] PIXEL_FORMAT_CONFIG_RESET  = 8'h66;
    localparam int         MCU_FMT_LSB                = 0;
    localparam int         RGB_FMT_LSB                = 4;
    localparam logic [7:0] DEF_MEM_WRITE_CMD          = 8'h2c;

    // pixel format codes
    localparam logic [2:0] FMT_16BPP                  = 3'h5;
    localparam logic [2:0] FMT_18BPP                  = 3'h6;

    // rgb timing modes
    localparam logic [1:0] RGB_TIMING_DE              = 2'h2;
    localparam logic [1:0] RGB_TIMING_SYNC            = 2'h3;

    // command byte sits on data pins 8..1 on this bus
    localparam int         CMD_LSB                    = 1;

    // 6-bit rgb transfer phases
    localparam logic [1:0] PHASE_FIRST                = 2'h0;
    localparam logic [1:0] PHASE_SECOND               = 2'h1;
    localparam logic [1:0] PHASE_THIRD                = 2'h2;
    localparam int         XFERS_6BIT                 = 3;

    // default geometry and buffering
    localparam int         DEF_H_ACTIVE               = 240;
    localparam int         DEF_V_ACTIVE               = 320;
    localparam int         DEF_FIFO_DEPTH             = 32;
    localparam int         PIXEL_W                    = 18;
    localparam int         ENTRY_W                    = PIXEL_W + 1;

    typedef enum logic [1:0] {
        MCU_IDLE,
        MCU_PARAM,
        MCU_PIXELS
    } pip_mcu_state_t;

    typedef struct packed {
        logic [3:0]  straps;
        logic        cs_n;
        logic        wr_n;
        logic        dc;
        logic [17:0] data;
        logic        pclk;
        logic        vs_n;
        logic        hs_n;
        logic        de;
    } pip_pins_t;

    // synchroniser reset values, so no false edge at release
    localparam pip_pins_t PINS_IDLE = '{straps: 4'h0, cs_n: 1'b1, wr_n: 1'b1, dc: 1'b0,
                                        data: 18'h00000, pclk: 1'b0, vs_n: 1'b1,
                                        hs_n: 1'b1, de: 1'b0};

    function automatic logic [5:0] pip_expand5(input logic [4:0] v);
        return {v, v[4]};
    endfunction

    function automatic logic pip_fmt_ok(input logic [2:0] fmt);
        return (fmt == FMT_16BPP) || (fmt == FMT_18BPP);
    endfunction

    // 16 bpp: r d15..11, g d10..5, b d4..0; 18 bpp: r d17..12, g d11..6, b d5..0
    function automatic logic [17:0] pip_unpack(input logic [2:0] fmt, input logic [17:0] d);
        if (fmt == FMT_16BPP) begin
            return {pip_expand5(d[15:11]), d[10:5], pip_expand5(d[4:0])};
        end
        return d;
    endfunction

endpackage

// ===== inc/pip_stream_if.sv
`timescale 1ns/1ps
interface pip_stream_if #(
    parameter int W = 19
) ();
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ===== rtl/pip_fifo.sv
`timescale 1ns/1ps
module pip_fifo #(
    parameter int WIDTH = 19,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic    clock,
    input wire logic    rst_n,
    // fill and drain sides
    pip_stream_if.snk   wr,
    pip_stream_if.src   rd
);
    // depth a power of two: pointers wrap on their own
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             out_valid;
    logic [WIDTH-1:0] out_data;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      next_count;
    logic             next_out_valid;
    logic [WIDTH-1:0] next_out_data;
    logic             push;
    logic             load;

    assign wr.ready  = (count != (AW+1)'(DEPTH));
    assign rd.valid  = out_valid;
    assign rd.data   = out_data;
    assign push      = wr.valid && wr.ready;
    // output register refills from memory; empty memory is never read
    assign load      = (count != '0) && (!out_valid || rd.ready);

    always_comb begin
        next_wr_ptr    = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr    = load ? rd_ptr + 1'b1 : rd_ptr;
        next_count     = count + (AW+1)'(push) - (AW+1)'(load);
        next_out_data  = load ? mem[rd_ptr] : out_data;
        next_out_valid = load ? 1'b1 : (rd.ready ? 1'b0 : out_valid);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            count     <= '0;
            out_valid <= 1'b0;
            out_data  <= '0;
        end else begin
            wr_ptr    <= next_wr_ptr;
            rd_ptr    <= next_rd_ptr;
            count     <= next_count;
            out_valid <= next_out_valid;
            out_data  <= next_out_data;
        end
    end

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr] <= wr.data;
        end
    end

endmodule // pip_fifo

// ===== testbench/pip_host_model.sv
`timescale 1ns/1ps
module pip_host_model
    import pip_pkg::*;
(
    // pacing clock
    input  wire logic        clock,
    // mcu bus
    output logic      [3:0]  interface_mode_straps,
    output logic             chip_select_n,
    output logic             write_strobe_n,
    output logic             data_command_select,
    output logic      [17:0] data_pins,
    // rgb video
    output logic             pixel_clock,
    output logic             vsync_n,
    output logic             hsync_n,
    output logic             data_enable
);
    initial begin
        interface_mode_straps = IM_PAR18_II;
        chip_select_n = 1'b1;
        write_strobe_n = 1'b1;
        data_command_select = 1'b0;
        data_pins = 18'h00000;
        pixel_clock = 1'b0;
        vsync_n = 1'b1;
        hsync_n = 1'b1;
        data_enable = 1'b0;
    end

    task automatic gap(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // 4 clocks per strobe level
    task automatic mcu_wr(input logic dc, input logic [17:0] d);
        gap(1);
        chip_select_n = 1'b0;
        data_command_select = dc;
        data_pins = d;
        write_strobe_n = 1'b0;
        gap(4);
        write_strobe_n = 1'b1;
        gap(4);
        chip_select_n = 1'b1;
        data_pins = ~d;
    endtask

    // clock idles outside frames; t_six sends only two transfers before its second vsync
    task automatic rgb_xfer(input logic [17:0] d, input logic de);
        data_pins = d;
        data_enable = de;
        gap(6);
        pixel_clock = 1'b1;
        gap(6);
        pixel_clock = 1'b0;
    endtask

    task automatic sync_fall(input logic vs);
        gap(1);
        if (vs) vsync_n = 1'b0;
        else hsync_n = 1'b0;
        gap(6);
        vsync_n = 1'b1;
        hsync_n = 1'b1;
        gap(6);
    endtask
endmodule // pip_host_model

// ===== testbench/pip_pixel_input_port_chk.sv
`timescale 1ns/1ps
module pip_pixel_input_port_chk
    import pip_pkg::*;
(
    // clock and reset
    input wire logic        clock,
    input wire logic        rst_n,
    // controls
    input wire logic        rgb_interface_enable,
    input wire logic        spi_cfg_write,
    input wire logic [7:0]  spi_cfg_addr,
    input wire logic [7:0]  spi_cfg_data,
    // outputs watched
    input wire logic [7:0]  pixel_format_config,
    input wire logic        mcu_mode_active,
    input wire logic        command_strobe,
    input wire logic [1:0]  transfer_phase,
    input wire logic        transfer_mismatch,
    input wire logic        pix_valid,
    input wire logic        pix_ready,
    input wire logic [17:0] pix_data
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    sequence s_cfg_wr;
        spi_cfg_write && spi_cfg_addr == REG_PIXEL_FORMAT_CONFIG;
    endsequence
    sequence s_stall;
        pix_valid && !pix_ready;
    endsequence
    AST_SPI_CFG: assert property (s_cfg_wr |=> pixel_format_config == $past(spi_cfg_data))
        else $error("serial config write lost");
    AST_CFG_HOLD: assert property (!spi_cfg_write && !mcu_mode_active && !$past(mcu_mode_active)
        |=> $stable(pixel_format_config)) else $error("config changed unasked");
    AST_RGB_NO_CMD: assert property (rgb_interface_enable && $past(rgb_interface_enable)
        |-> !command_strobe) else $error("command in rgb mode");
    AST_MCU_MODE: assert property (mcu_mode_active |-> !rgb_interface_enable)
        else $error("mcu and rgb both on");
    AST_CMD_PULSE: assert property (command_strobe |=> !command_strobe)
        else $error("command strobe held");
    AST_PHASE_STEP: assert property ($changed(transfer_phase)
        |-> transfer_phase == $past(transfer_phase) + 2'h1 || transfer_phase == PHASE_FIRST)
        else $error("phase skipped");
    AST_MISMATCH_CLR: assert property (transfer_mismatch |-> transfer_phase == PHASE_FIRST)
        else $error("phase not reset");
    AST_MISMATCH_PULSE: assert property (transfer_mismatch |=> !transfer_mismatch)
        else $error("mismatch flag held");
    AST_PIX_HOLD: assert property (s_stall |=> pix_valid && $stable(pix_data))
        else $error("stalled pixel changed");
endmodule // pip_pixel_input_port_chk

bind pip_pixel_input_port pip_pixel_input_port_chk pip_pixel_input_port_chk_i (.*);

// ===== testbench/pip_pixel_input_port_tb.sv
`timescale 1ns/1ps
module pip_pixel_input_port_tb;
    import pip_pkg::*;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  interface_mode_straps;
    logic        chip_select_n, write_strobe_n, data_command_select;
    logic [17:0] data_pins;
    logic        pixel_clock, vsync_n, hsync_n, data_enable;
    logic        rgb_interface_enable = 1'b0;
    logic        rgb_six_bit_select = 1'b0;
    logic [1:0]  rgb_timing_mode = 2'h0;
    logic [7:0]  vertical_porch_settings = 8'h00;
    logic [7:0]  horizontal_porch_settings = 8'h00;
    logic        spi_cfg_write = 1'b0;
    logic [7:0]  spi_cfg_addr = 8'h00;
    logic [7:0]  spi_cfg_data = 8'h00;
    logic        pix_ready = 1'b0;
    logic [7:0]  pixel_format_config, command_code;
    logic        mcu_mode_active, command_strobe, transfer_mismatch, accept_ready;
    logic [1:0]  transfer_phase;
    logic        pix_valid, pix_frame_start;
    logic [17:0] pix_data;
    int          miscompares = 0;
    int          samples_checked = 0;

    always #2 clock = ~clock;

    pip_host_model pip_host_model_i (.*);

    pip_pixel_input_port #(.H_ACTIVE(4), .V_ACTIVE(2)) pip_pixel_input_port_i (.*);

    task automatic check(input logic [18:0] seen, input logic [18:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic pop(output logic [18:0] got);
        int n;
        n = 0;
        @(posedge clock);
        #1;
        pix_ready = 1'b1;
        @(posedge clock);
        while (pix_valid !== 1'b1 && n < 60) begin
            @(posedge clock);
            n++;
        end
        got = {pix_frame_start, pix_data};
        #1;
        pix_ready = 1'b0;
    endtask

    task automatic spi(input logic [7:0] v);
        @(posedge clock);
        #1;
        spi_cfg_write = 1'b1;
        spi_cfg_addr = REG_PIXEL_FORMAT_CONFIG;
        spi_cfg_data = v;
        @(posedge clock);
        #1;
        spi_cfg_write = 1'b0;
        @(posedge clock);
        #1;
        check({11'h0, pixel_format_config}, {11'h0, v});
    endtask

    task automatic t_mcu();
        logic [18:0] got;
        int n;
        pip_host_model_i.mcu_wr(1'b0, {9'h0, DEF_MEM_WRITE_CMD, 1'b0});
        check({11'h0, command_code}, {11'h0, DEF_MEM_WRITE_CMD});
        pip_host_model_i.mcu_wr(1'b1, 18'h2a5c3);
        pop(got);
        check(got, {1'b1, 18'h2a5c3});
        n = 0;
        while (accept_ready === 1'b1 && n < 40) begin
            pip_host_model_i.mcu_wr(1'b1, 18'(n));
            n++;
        end
        check(19'(n >= DEF_FIFO_DEPTH), 19'h1);
        for (int i = 0; i < n; i++) begin
            pop(got);
            check(got, {1'b0, 18'(i)});
        end
    endtask

    task automatic t_mcu16();
        logic [18:0] got;
        logic [17:0] d;
        d = 18'h3b6d5;
        pip_host_model_i.mcu_wr(1'b0, {9'h0, REG_PIXEL_FORMAT_CONFIG, 1'b0});
        pip_host_model_i.mcu_wr(1'b1, {9'h0, 8'h65, 1'b0});
        check({11'h0, pixel_format_config}, 19'h65);
        pip_host_model_i.mcu_wr(1'b0, {9'h0, DEF_MEM_WRITE_CMD, 1'b0});
        pip_host_model_i.mcu_wr(1'b1, d);
        pop(got);
        check(got, {1'b1, d[15:11], d[15], d[10:5], d[4:0], d[4]});
    endtask

    task automatic t_rgb_de();
        logic [18:0] got;
        rgb_interface_enable = 1'b1;
        rgb_timing_mode = RGB_TIMING_DE;
        spi(8'h66);
        pip_host_model_i.sync_fall(1'b1);
        pip_host_model_i.rgb_xfer(18'h15555, 1'b0);
        pip_host_model_i.rgb_xfer(18'h0abcd, 1'b1);
        pop(got);
        check(got, {1'b1, 18'h0abcd});
        spi(8'h56);
        pip_host_model_i.rgb_xfer(18'h0f0f3, 1'b1);
        pop(got);
        check(got, {1'b0, 5'h1e, 1'b1, 6'h07, 5'h13, 1'b1});
    endtask

    task automatic t_six();
        logic [18:0] got;
        spi(8'h66);
        rgb_six_bit_select = 1'b1;
        pip_host_model_i.sync_fall(1'b1);
        pip_host_model_i.rgb_xfer(18'h00015, 1'b1);
        pip_host_model_i.rgb_xfer(18'h0002a, 1'b1);
        check({17'h0, transfer_phase}, {17'h0, PHASE_THIRD});
        pip_host_model_i.sync_fall(1'b1);
        check({17'h0, transfer_phase}, {17'h0, PHASE_FIRST});
        pip_host_model_i.rgb_xfer(18'h0003f, 1'b1);
        pip_host_model_i.rgb_xfer(18'h00000, 1'b1);
        pip_host_model_i.rgb_xfer(18'h0002d, 1'b1);
        pop(got);
        check(got, {1'b1, 6'h3f, 6'h00, 6'h2d});
        check({17'h0, transfer_phase}, {17'h0, PHASE_FIRST});
    endtask

    task automatic t_sync();
        logic [18:0] got;
        rgb_six_bit_select = 1'b0;
        rgb_timing_mode = RGB_TIMING_SYNC;
        vertical_porch_settings = 8'h01;
        horizontal_porch_settings = 8'h01;
        pip_host_model_i.sync_fall(1'b1);
        pip_host_model_i.sync_fall(1'b0);
        pip_host_model_i.rgb_xfer(18'h00001, 1'b1);
        pip_host_model_i.rgb_xfer(18'h1c3a5, 1'b0);
        pop(got);
        check(got, {1'b1, 18'h1c3a5});
    endtask

    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clock);
        #1;
        rst_n = 1'b1;
        repeat (4) @(posedge clock);
        #1;
        t_mcu();
        t_mcu16();
        t_rgb_de();
        t_six();
        t_sync();
        tally_and_finish();
    end

    initial begin
        #100000;
        miscompares++;
        tally_and_finish();
    end
endmodule // pip_pixel_input_port_tb
